// ### core/spr_sleep_power_reset_control.sv
// What this block does
// - Mode field bits 3:1: 000 idle, 001 noise reduction, 010 power-down, 100 standby.
// - Halt instruction enters the chosen mode only while the arm bit is one.
// - Serial port gate bit 2 stops the serial port clock.
// - Converter gate bit 1 stops converter; comparator loses the input multiplexer.
// - Timer gate bit 0 freezes timer; clearing resumes it unchanged.
// - An enabled converter stays powered in every low-power mode.
// - After converter off then on, next conversion is extended.
// - Comparator is switched off automatically in power-down.
// - Voltage reference is on whenever comparator or converter needs it.
// - An enabled watchdog keeps running in every low-power mode.
// - With io clock stopped, input buffers off except wake-up pins.
// - Reset clears registers; afterwards execution starts at the reset vector.
// - Port reset follows the supply sources immediately, without a clock; the filtered pin and the watchdog pass through registers first.
// - Internal reset is stretched by a time-out after all sources end.
// - Four sources: supply rise, supply monitor, reset pin, watchdog.
// - Reset pin low longer than minimum pulse gives an external reset.
// - Watchdog expiry with reset mode enabled gives a watchdog reset.
// - Interrupt wakes: start-up time plus four stall cycles, then handler.
// - Each mode stops its documented clock domains; only power-down also stops the oscillator.
// - Reset during sleep wakes the device into the reset vector.
// - Gated peripheral is frozen and its registers are inaccessible.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/10ps
module spr_sleep_power_reset_control #(
    parameter int unsigned PINS           = 8,
    parameter int unsigned STARTUP_CYCLES = 16,
    parameter int unsigned EXT_MIN_CYCLES = 4,
    parameter int unsigned TOUT_CYCLES    = 1024
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                rstn,
    // Avalon-MM register slave
    input  wire logic [7:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic [31:0]              avs_readdata,
    output logic                     avs_waitrequest,
    // CPU core
    input  wire logic                halt_instr,
    input  wire logic                wake_irq,
    output logic                     cpu_from_vector,
    output logic                     irq_resume,
    // Reset sources
    input  wire logic                supply_rise_reset,
    input  wire logic                supply_level_monitor_reset,
    input  wire logic                ext_reset_n,
    input  wire logic                wdt_expire,
    input  wire logic                wdt_reset_mode,
    // Reset outputs
    output logic                     port_reset,
    output logic                     core_reset,
    // Clock domains
    output spr_pkg::spr_clk_en_t     clk_en,
    // Peripheral gating
    output logic                     timer_clk_en,
    output logic                     serial_clk_en,
    output logic                     conv_clk_en,
    output logic                     timer_access_en,
    output logic                     serial_access_en,
    output logic                     conv_access_en,
    output logic                     comp_mux_allow,
    // Analog and watchdog
    input  wire logic                conv_enable,
    input  wire logic                conv_uses_vref,
    input  wire logic                conv_start,
    input  wire logic                comp_enable,
    input  wire logic                comp_uses_vref,
    input  wire logic                wdt_enable,
    output logic                     conv_powered,
    output logic                     conv_extended,
    output logic                     comp_powered,
    output logic                     vref_on,
    output logic                     wdt_run,
    // Digital input buffers
    input  wire logic [PINS-1:0]     digital_input_disable_reg,
    input  wire logic [PINS-1:0]     wake_pin_mask,
    output logic [PINS-1:0]          input_buf_en
);

    localparam logic [15:0] STARTUP_LAST = 16'(STARTUP_CYCLES - 1);
    localparam logic [15:0] STALL_LAST   = 16'(spr_pkg::WAKE_STALL_CYCLES - 1);

    typedef struct packed {
        spr_pkg::spr_state_t  state;
        logic [2:0]           sleep_mode;
        logic [15:0]          count;
        logic [7:0]           clock_gate;
        logic [7:0]           low_power;
        logic                 ack;
        logic [31:0]          readdata;
        logic                 wdt_rst;
        logic                 rst_q;
        logic                 cpu_from_vector;
        logic                 irq_resume;
        spr_pkg::spr_clk_en_t clk_en;
        logic                 timer_clk_en;
        logic                 serial_clk_en;
        logic                 conv_clk_en;
        logic                 timer_access_en;
        logic                 serial_access_en;
        logic                 conv_access_en;
        logic                 comp_mux_allow;
        logic                 conv_powered;
        logic                 conv_extended;
        logic                 comp_powered;
        logic                 vref_on;
        logic                 wdt_run;
        logic [PINS-1:0]      input_buf_en;
    } spr_top_state_t;

    spr_top_state_t q;
    spr_top_state_t next_q;
    logic           ext_active;
    logic           src_active;
    logic           core_reset_w;

    spr_pulse_filter #(
        .MIN_CYCLES (EXT_MIN_CYCLES)
    ) u_pin_filter (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .level_n    (ext_reset_n),
        .asserted   (ext_active)
    );

    assign src_active = supply_rise_reset | supply_level_monitor_reset | ext_active | q.wdt_rst;

    spr_reset_stretch #(
        .TOUT_CYCLES (TOUT_CYCLES)
    ) u_stretch (
        .core_clk    (core_clk),
        .rstn        (rstn),
        .src_active  (src_active),
        .port_reset  (port_reset),
        .core_reset  (core_reset_w)
    );

    assign core_reset = core_reset_w;

    always_comb
    begin
        logic        take_wr;
        logic        mode_ok;
        logic        pd_now;
        logic [2:0]  mode_field;
        next_q                 = q;
        next_q.cpu_from_vector = 1'b0;
        next_q.irq_resume      = 1'b0;
        take_wr                = avs_write & q.ack & avs_byteenable[0];
        mode_field             = q.low_power[spr_pkg::MODE_MSB:spr_pkg::MODE_LSB];

        // One wait cycle: request seen, then answered the following cycle.
        next_q.ack = (avs_read | avs_write) & ~q.ack;
        if ((avs_read | avs_write) && !q.ack)
        begin
            case (avs_address)
                spr_pkg::ADDR_CLOCK_GATE: next_q.readdata = {24'h000000, q.clock_gate};
                spr_pkg::ADDR_LOW_POWER:  next_q.readdata = {24'h000000, q.low_power};
                spr_pkg::ADDR_STATUS:     next_q.readdata = {26'h0000000, q.conv_extended,
                                                             q.sleep_mode[0], q.state,
                                                             q.conv_powered, q.comp_powered};
                default:                  next_q.readdata = 32'h00000000;
            endcase
        end

        // masked writes keep undefined bits zero
        if (take_wr && avs_address == spr_pkg::ADDR_CLOCK_GATE)
            next_q.clock_gate = avs_writedata[7:0] & spr_pkg::CLOCK_GATE_MASK;
        if (take_wr && avs_address == spr_pkg::ADDR_LOW_POWER)
            next_q.low_power = avs_writedata[7:0] & spr_pkg::LOW_POWER_MASK;

        next_q.wdt_rst = wdt_expire & wdt_reset_mode;

        mode_ok = (mode_field == spr_pkg::MODE_IDLE) || (mode_field == spr_pkg::MODE_NOISE_RED)
               || (mode_field == spr_pkg::MODE_POWER_DOWN)
               || (mode_field == spr_pkg::MODE_STANDBY);

        case (q.state)
            spr_pkg::SPR_ACTIVE:
            begin
                if (halt_instr && q.low_power[spr_pkg::DOZE_ARM_POS] && mode_ok)
                begin
                    next_q.state      = spr_pkg::SPR_SLEEP;
                    next_q.sleep_mode = mode_field;
                end
            end
            spr_pkg::SPR_SLEEP:
            begin
                if (wake_irq)
                begin
                    next_q.state = spr_pkg::SPR_STARTUP;
                    next_q.count = spr_pkg::COUNT_ZERO;
                end
            end
            spr_pkg::SPR_STARTUP:
            begin
                if (q.count == STARTUP_LAST)
                begin
                    next_q.state = spr_pkg::SPR_STALL;
                    next_q.count = spr_pkg::COUNT_ZERO;
                end
                else
                begin
                    next_q.count = q.count + 16'h0001;
                end
            end
            spr_pkg::SPR_STALL:
            begin
                if (q.count == STALL_LAST)
                begin
                    next_q.state      = spr_pkg::SPR_ACTIVE;
                    next_q.irq_resume = 1'b1;
                end
                else
                begin
                    next_q.count = q.count + 16'h0001;
                end
            end
            default:
            begin
                next_q.state = spr_pkg::SPR_ACTIVE;
            end
        endcase

        // reset clears registers and leaves sleep
        if (core_reset_w)
        begin
            next_q.state      = spr_pkg::SPR_ACTIVE;
            next_q.sleep_mode = spr_pkg::MODE_IDLE;
            next_q.count      = spr_pkg::COUNT_ZERO;
            next_q.clock_gate = spr_pkg::CLOCK_GATE_RESET;
            next_q.low_power  = spr_pkg::LOW_POWER_RESET;
            next_q.irq_resume = 1'b0;
        end
        next_q.rst_q = core_reset_w;
        // start from the reset vector on release
        next_q.cpu_from_vector = q.rst_q & ~core_reset_w;

        next_q.clk_en = spr_pkg::CLK_ALL_ON;
        case (next_q.state)
            spr_pkg::SPR_SLEEP:
            begin
                next_q.clk_en.cpu = 1'b0;
                next_q.clk_en.nvm = 1'b0;
                case (next_q.sleep_mode)
                    spr_pkg::MODE_NOISE_RED:
                        next_q.clk_en.io = 1'b0;
                    spr_pkg::MODE_POWER_DOWN:
                        next_q.clk_en = '0;
                    spr_pkg::MODE_STANDBY:
                        next_q.clk_en = '{osc: 1'b1, adc: 1'b0, io: 1'b0, nvm: 1'b0, cpu: 1'b0};
                    default:
                        next_q.clk_en.io = 1'b1;
                endcase
            end
            spr_pkg::SPR_STARTUP, spr_pkg::SPR_STALL:
                next_q.clk_en.cpu = 1'b0;
            default:
                next_q.clk_en = spr_pkg::CLK_ALL_ON;
        endcase

        next_q.timer_clk_en  = next_q.clk_en.io & ~next_q.clock_gate[spr_pkg::TIMER_GATE_POS];
        next_q.serial_clk_en = next_q.clk_en.io & ~next_q.clock_gate[spr_pkg::SERIAL_GATE_POS];
        next_q.conv_clk_en   = next_q.clk_en.adc & ~next_q.clock_gate[spr_pkg::CONV_GATE_POS];
        next_q.timer_access_en  = ~next_q.clock_gate[spr_pkg::TIMER_GATE_POS];
        next_q.serial_access_en = ~next_q.clock_gate[spr_pkg::SERIAL_GATE_POS];
        next_q.conv_access_en   = ~next_q.clock_gate[spr_pkg::CONV_GATE_POS];
        next_q.comp_mux_allow   = ~next_q.clock_gate[spr_pkg::CONV_GATE_POS];

        next_q.conv_powered = conv_enable & ~next_q.clock_gate[spr_pkg::CONV_GATE_POS];
        // set on power-up wins over the clear
        if (conv_start)
            next_q.conv_extended = 1'b0;
        if (next_q.conv_powered && !q.conv_powered)
            next_q.conv_extended = 1'b1;

        pd_now = (next_q.state == spr_pkg::SPR_SLEEP)
              && (next_q.sleep_mode == spr_pkg::MODE_POWER_DOWN);
        next_q.comp_powered = comp_enable & ~pd_now;
        next_q.vref_on = (next_q.comp_powered & comp_uses_vref)
                       | (next_q.conv_powered & conv_uses_vref);
        next_q.wdt_run = wdt_enable;
        // buffers off while io clock stopped, wake pins kept
        next_q.input_buf_en = ~digital_input_disable_reg
                            & (next_q.clk_en.io ? {PINS{1'b1}} : wake_pin_mask);
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q              <= '0;
            q.state        <= spr_pkg::SPR_ACTIVE;
            q.clock_gate   <= spr_pkg::CLOCK_GATE_RESET;
            q.low_power    <= spr_pkg::LOW_POWER_RESET;
            q.rst_q        <= 1'b1;
            q.clk_en       <= spr_pkg::CLK_ALL_ON;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign avs_readdata     = q.readdata;
    assign avs_waitrequest  = ~q.ack;
    assign cpu_from_vector  = q.cpu_from_vector;
    assign irq_resume       = q.irq_resume;
    assign clk_en           = q.clk_en;
    assign timer_clk_en     = q.timer_clk_en;
    assign serial_clk_en    = q.serial_clk_en;
    assign conv_clk_en      = q.conv_clk_en;
    assign timer_access_en  = q.timer_access_en;
    assign serial_access_en = q.serial_access_en;
    assign conv_access_en   = q.conv_access_en;
    assign comp_mux_allow   = q.comp_mux_allow;
    assign conv_powered     = q.conv_powered;
    assign conv_extended    = q.conv_extended;
    assign comp_powered     = q.comp_powered;
    assign vref_on          = q.vref_on;
    assign wdt_run          = q.wdt_run;
    assign input_buf_en     = q.input_buf_en;

endmodule // spr_sleep_power_reset_control

// ### core/spr_pkg.sv
// Shared constants and types for the sleep, clock gating and reset controller.
package spr_pkg;

    // Register indices; the Avalon byte address is four times the index.
    localparam logic [7:0] IDX_CLOCK_GATE     = 8'h35;
    localparam logic [7:0] IDX_STATUS         = 8'h36;
    localparam logic [7:0] IDX_LOW_POWER      = 8'h3A;
    localparam logic [7:0] ADDR_CLOCK_GATE    = 8'(IDX_CLOCK_GATE * 4);
    localparam logic [7:0] ADDR_STATUS        = 8'(IDX_STATUS * 4);
    localparam logic [7:0] ADDR_LOW_POWER     = 8'(IDX_LOW_POWER * 4);

    // Reset values and implemented-bit masks.
    localparam logic [7:0] CLOCK_GATE_RESET   = 8'h00;
    localparam logic [7:0] LOW_POWER_RESET    = 8'h00;
    localparam logic [7:0] CLOCK_GATE_MASK    = 8'h07;
    localparam logic [7:0] LOW_POWER_MASK     = 8'h0F;

    // Field positions.
    localparam int unsigned DOZE_ARM_POS      = 0;
    localparam int unsigned MODE_LSB          = 1;
    localparam int unsigned MODE_MSB          = 3;
    localparam int unsigned TIMER_GATE_POS    = 0;
    localparam int unsigned CONV_GATE_POS     = 1;
    localparam int unsigned SERIAL_GATE_POS   = 2;

    // Low-power mode codes of power_mode_choice.
    localparam logic [2:0] MODE_IDLE          = 3'h0;
    localparam logic [2:0] MODE_NOISE_RED     = 3'h1;
    localparam logic [2:0] MODE_POWER_DOWN    = 3'h2;
    localparam logic [2:0] MODE_STANDBY       = 3'h4;

    // Cycle counts.
    localparam int unsigned WAKE_STALL_CYCLES = 4;
    localparam int unsigned COUNT_W           = 16;
    localparam logic [15:0] COUNT_ZERO        = 16'h0000;

    // Sleep sequencer states, Gray coded along active, sleep, start-up, stall.
    typedef enum logic [1:0] {
        SPR_ACTIVE  = 2'h0,
        SPR_SLEEP   = 2'h1,
        SPR_STARTUP = 2'h3,
        SPR_STALL   = 2'h2
    } spr_state_t;

    // Clock domain enables driven to the clock generator.
    typedef struct packed {
        logic osc;
        logic adc;
        logic io;
        logic nvm;
        logic cpu;
    } spr_clk_en_t;

    localparam spr_clk_en_t CLK_ALL_ON = 5'h1F;

endpackage

// ### core/spr_pulse_filter.sv
// Low-level pulse filter for the external reset pin.
`timescale 1ns/10ps
module spr_pulse_filter #(
    parameter int unsigned MIN_CYCLES = 4
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rstn,
    // Pin and result
    input  wire logic level_n,
    output logic      asserted
);

    typedef struct packed {
        logic [15:0] count;
        logic        asserted;
    } spr_filt_state_t;

    localparam logic [15:0] LIMIT = 16'(MIN_CYCLES);

    spr_filt_state_t q;
    spr_filt_state_t next_q;

    // The reset is raised only once the pin has been low longer than the minimum.
    always_comb
    begin
        next_q = q;
        if (level_n)
        begin
            next_q.count    = spr_pkg::COUNT_ZERO;
            next_q.asserted = 1'b0;
        end
        else if (q.count < LIMIT)
        begin
            next_q.count = q.count + 16'h0001;
        end
        else
        begin
            next_q.asserted = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            q <= '0;
        else
            q <= next_q;
    end

    assign asserted = q.asserted;

endmodule // spr_pulse_filter

// ### core/spr_reset_stretch.sv
// Reset stretcher: asserts without a clock, releases after a time-out count.
`timescale 1ns/10ps
module spr_reset_stretch #(
    parameter int unsigned TOUT_CYCLES = 1024
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rstn,
    // Combined reset sources, active high
    input  wire logic src_active,
    // Reset outputs
    output logic      port_reset,
    output logic      core_reset
);

    typedef struct packed {
        logic [15:0] count;
        logic        port_reset;
        logic        core_reset;
    } spr_stretch_state_t;

    localparam logic [15:0] LAST = 16'(TOUT_CYCLES - 1);

    spr_stretch_state_t q;
    spr_stretch_state_t next_q;
    logic               arst_n;

    // Any source forces both resets at once, with or without a running clock.
    assign arst_n = rstn & ~src_active;

    always_comb
    begin
        next_q            = q;
        next_q.port_reset = 1'b0;
        if (q.core_reset)
        begin
            if (q.count == LAST)
                next_q.core_reset = 1'b0;
            else
                next_q.count = q.count + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            q <= '{count: 16'h0000, port_reset: 1'b1, core_reset: 1'b1};
        else
            q <= next_q;
    end

    assign port_reset = q.port_reset;
    assign core_reset = q.core_reset;

endmodule // spr_reset_stretch

// ### sim/spr_cpu_model.sv
// Behavioural CPU side: halt and wake events and the converter enable.
`timescale 1ns/10ps
module spr_cpu_model (
    // Clock
    input wire logic core_clk,
    // Core requests
    output logic     halt_instr,
    output logic     wake_irq,
    output logic     conv_enable
);
    initial
    begin
        halt_instr  = 1'b0;
        wake_irq    = 1'b0;
        conv_enable = 1'b0;
    end
    task halt_now;
        halt_instr <= 1'b1;
        @(posedge core_clk);
        halt_instr <= 1'b0;
    endtask
    // A pending interrupt lasts one cycle, so wake timing is exact.
    task wake_now;
        wake_irq <= 1'b1;
        @(posedge core_clk);
        wake_irq <= 1'b0;
    endtask
    task conv_set(input logic en);
        conv_enable <= en;
        @(posedge core_clk);
    endtask
endmodule // spr_cpu_model

// ### sim/spr_properties.sv
// Concurrent checks on the controller's ports.
`timescale 1ns/10ps
module spr_properties #(
    parameter int unsigned PINS           = 8,
    parameter int unsigned STARTUP_CYCLES = 16,
    parameter int unsigned TOUT_CYCLES    = 1024
) (
    // Clock and reset
    input wire logic                 core_clk,
    input wire logic                 rstn,
    // Core side
    input wire logic                 wake_irq,
    input wire logic                 irq_resume,
    input wire logic                 cpu_from_vector,
    // Reset sources and outputs
    input wire logic                 supply_rise_reset,
    input wire logic                 wdt_expire,
    input wire logic                 wdt_reset_mode,
    input wire logic                 port_reset,
    input wire logic                 core_reset,
    // Power state
    input wire spr_pkg::spr_clk_en_t clk_en,
    input wire logic                 comp_powered,
    input wire logic                 wdt_enable,
    input wire logic                 wdt_run,
    input wire logic [PINS-1:0]      wake_pin_mask,
    input wire logic [PINS-1:0]      input_buf_en
);
    localparam int WAKE_LAT = STARTUP_CYCLES + 5;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    port_follow_a: assert property (supply_rise_reset |-> port_reset && core_reset)
        else $error("reset outputs not raised by source");
    wdt_reset_a: assert property (wdt_expire && wdt_reset_mode |=> core_reset)
        else $error("watchdog reset missing");
    stretch_a: assert property ($fell(core_reset) |->
        $past(port_reset, TOUT_CYCLES) && !$past(port_reset, TOUT_CYCLES - 1))
        else $error("internal reset stretch wrong");
    vector_a: assert property ($fell(core_reset) |=> cpu_from_vector)
        else $error("no start from reset vector");
    comp_off_a: assert property (clk_en == 5'h00 ##1 clk_en == 5'h00 |-> !comp_powered)
        else $error("comparator powered in power-down");
    wdt_keep_a: assert property ($past(rstn) && $past(wdt_enable) && !core_reset |-> wdt_run)
        else $error("watchdog stopped");
    wake_lat_a: assert property ($rose(irq_resume) |-> $past(wake_irq, WAKE_LAT))
        else $error("wake latency wrong");
    buf_off_a: assert property (!clk_en.io ##1 !clk_en.io |->
        (input_buf_en & ~wake_pin_mask) == '0)
        else $error("input buffer left on");
    cover property ($rose(irq_resume));
    cover property ($fell(core_reset));
    cover property (clk_en == 5'h00);
endmodule // spr_properties
bind spr_sleep_power_reset_control spr_properties #(
    .PINS(PINS), .STARTUP_CYCLES(STARTUP_CYCLES), .TOUT_CYCLES(TOUT_CYCLES)
) i_props (
    .core_clk, .rstn, .wake_irq, .irq_resume, .cpu_from_vector, .supply_rise_reset,
    .wdt_expire, .wdt_reset_mode, .port_reset, .core_reset, .clk_en, .comp_powered,
    .wdt_enable, .wdt_run, .wake_pin_mask, .input_buf_en
);

// ### sim/spr_sleep_power_reset_control_tb_top.sv
// Self-checking bench for the sleep, clock gating and reset controller.
`timescale 1ns/10ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_total++; $display("BAD %s exp %0h got %0h", n, e, s); end end
`define WAIT(c) begin n = 0; while (!(c) && n < 3000) begin @(posedge core_clk); n++; end if (n >= 3000) begin err_total++; complete_run(); end end
module spr_sleep_power_reset_control_tb_top;
    localparam logic [7:0] CG = spr_pkg::ADDR_CLOCK_GATE;
    localparam logic [7:0] LP = spr_pkg::ADDR_LOW_POWER;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [1:0]  src = 2'h0;
    logic        ext_reset_n = 1'b1;
    logic        wdt_expire = 1'b0;
    logic        wdt_reset_mode = 1'b0;
    logic        conv_uses_vref = 1'b1;
    logic        comp_enable = 1'b1;
    logic        wdt_enable = 1'b1;
    logic [7:0]  wake_pin_mask = 8'h0F;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, halt_instr, wake_irq, conv_enable, cpu_from_vector;
    logic        irq_resume, port_reset, core_reset, timer_clk_en, serial_clk_en, conv_extended;
    logic        conv_clk_en, comp_mux_allow, conv_powered, comp_powered, vref_on, wdt_run;
    logic [7:0]  input_buf_en, q;
    logic [4:0]  clk_en;
    logic [2:0]  acc;
    logic [7:0]  lp_code [6] = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h07, 8'h04};
    logic [4:0]  lp_clk [6] = '{5'h1C, 5'h18, 5'h00, 5'h10, 5'h1F, 5'h1F};
    int          n, err_total = 0, check_count = 0;
    spr_sleep_power_reset_control #(
        .PINS(8), .STARTUP_CYCLES(16), .EXT_MIN_CYCLES(4), .TOUT_CYCLES(4)
    ) i_dut (
        .core_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .halt_instr, .wake_irq,
        .cpu_from_vector, .irq_resume, .supply_rise_reset(src[0]),
        .supply_level_monitor_reset(src[1]), .ext_reset_n, .wdt_expire, .wdt_reset_mode,
        .port_reset, .core_reset, .clk_en(clk_en), .timer_clk_en, .serial_clk_en, .conv_clk_en,
        .timer_access_en(acc[0]), .serial_access_en(acc[1]), .conv_access_en(acc[2]),
        .comp_mux_allow, .conv_enable, .conv_uses_vref, .conv_start(~conv_uses_vref),
        .comp_enable, .comp_uses_vref(comp_enable), .wdt_enable, .conv_powered,
        .conv_extended, .comp_powered, .vref_on, .wdt_run, .digital_input_disable_reg(8'h00),
        .wake_pin_mask, .input_buf_en
    );
    spr_cpu_model i_cpu (.core_clk, .halt_instr, .wake_irq, .conv_enable);
    always #5 core_clk = ~core_clk;
    task complete_run;
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_write     <= w;
        avs_read      <= !w;
        `WAIT(avs_waitrequest === 1'b0)
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic reg_is(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK("register", e, q)
    endtask
    initial
    begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        `WAIT(core_reset === 1'b0)
        reg_is(CG, 8'h00); // reset value
        bus(1'b1, CG, 8'hFF);
        reg_is(CG, 8'h07); // spare bits
        `CHK("gated", 4'h0, {timer_clk_en, conv_clk_en, serial_clk_en, comp_mux_allow})
        `CHK("access", 3'h0, acc)
        bus(1'b1, CG, 8'h00);
        @(posedge core_clk);
        `CHK("ungated", 4'hF, {timer_clk_en, conv_clk_en, serial_clk_en, comp_mux_allow})
        `CHK("access", 3'h7, acc)
        reg_is(8'h00, 8'h00); // unmapped place
        bus(1'b1, LP, 8'hFF);
        reg_is(LP, 8'h0F); // spare bits
        i_cpu.conv_set(1'b1);
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b1, LP, lp_code[i]); // arm before halt; 04 leaves the arm bit clear
            i_cpu.halt_now();
            repeat (2) @(posedge core_clk);
            `CHK("clocks", lp_clk[i], clk_en)
            `CHK("comparator", lp_clk[i] != 5'h00, comp_powered)
            `CHK("analog", 4'hF, {conv_powered, vref_on, wdt_run, conv_extended})
            `CHK("buffers", lp_clk[i][2] ? 8'hFF : 8'h0F, input_buf_en)
            if (lp_clk[i] != 5'h1F)
            begin
                i_cpu.wake_now();
                `WAIT(irq_resume === 1'b1)
                `CHK("resume", 5'h1F, clk_en)
            end
            bus(1'b1, LP, 8'h00); // disarm after wake
        end
        for (int i = 0; i < 2; i++)
        begin
            bus(1'b1, LP, 8'h05);
            i_cpu.halt_now();
            src[i] <= 1'b1;
            @(posedge core_clk);
            `CHK("port reset", 1'b1, port_reset)
            src[i] <= 1'b0;
            `WAIT(core_reset === 1'b0)
            `CHK("wake by reset", 5'h1F, clk_en)
        end
        ext_reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        ext_reset_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        `CHK("short pin", 1'b0, port_reset) // short pulse
        ext_reset_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        `CHK("long pin", 1'b1, port_reset) // long pulse
        ext_reset_n <= 1'b1;
        `WAIT(core_reset === 1'b0)
        i_cpu.conv_set(1'b0);
        bus(1'b1, CG, 8'h07);
        for (int m = 0; m < 2; m++)
        begin
            wdt_reset_mode <= m[0];
            wdt_expire     <= 1'b1;
            @(posedge core_clk);
            wdt_expire <= 1'b0;
            repeat (2) @(posedge core_clk);
            `CHK("watchdog", m[0], core_reset)
        end
        {comp_enable, conv_uses_vref, wdt_enable} <= 3'h0;
        `WAIT(core_reset === 1'b0)
        reg_is(CG, 8'h00); // cleared again
        `CHK("analog off", 4'h0, {conv_extended, wdt_run, vref_on, comp_powered})
        complete_run();
    end
endmodule // spr_sleep_power_reset_control_tb_top
